//--- shared/nia_pkg.sv
// package: constants and types for the navigation input alarm monitor
package nia_pkg;
  // input sources
  localparam int          NUM_SRC        = 4;
  localparam int          SRC_HEADING    = 0;
  localparam int          SRC_TURN_RATE  = 1;
  localparam int          SRC_SPEED      = 2;
  localparam int          SRC_LATITUDE   = 3;

  // timing
  localparam longint      CLK_HZ         = 64'd10_000_000;
  localparam longint      SILENCE_SEC    = 64'd10;
  localparam longint      SILENCE_CYCLES = CLK_HZ * SILENCE_SEC;
  localparam int          TMR_W          = 27;

  // alarm codes, three decimal digits held as a 10-bit binary value
  localparam logic [9:0]  CODE_NONE      = 10'h000;
  localparam logic [9:0]  CODE_HDG_TMO   = 10'd90;
  localparam logic [9:0]  CODE_HDG_PROTO = 10'd91;
  localparam logic [9:0]  CODE_HDG_CSUM  = 10'd92;
  localparam logic [9:0]  CODE_HDG_INVAL = 10'd93;
  localparam logic [9:0]  CODE_TRN_TMO   = 10'd94;
  localparam logic [9:0]  CODE_TRN_CSUM  = 10'd96;
  localparam logic [9:0]  CODE_TRN_INVAL = 10'd97;
  localparam logic [9:0]  CODE_SPD_TMO   = 10'd100;
  localparam logic [9:0]  CODE_SPD_CSUM  = 10'd102;
  localparam logic [9:0]  CODE_SPD_INVAL = 10'd103;
  localparam logic [9:0]  CODE_LAT_TMO   = 10'd110;
  localparam logic [9:0]  CODE_LAT_CSUM  = 10'd112;
  localparam logic [9:0]  CODE_LAT_INVAL = 10'd113;

  // alarm vector bit positions
  localparam int          NUM_ALM        = 13;
  localparam int          A_HDG_TMO      = 0;
  localparam int          A_HDG_PROTO    = 1;
  localparam int          A_HDG_CSUM     = 2;
  localparam int          A_HDG_INVAL    = 3;
  localparam int          A_TRN_TMO      = 4;
  localparam int          A_TRN_CSUM     = 5;
  localparam int          A_TRN_INVAL    = 6;
  localparam int          A_SPD_TMO      = 7;
  localparam int          A_SPD_CSUM     = 8;
  localparam int          A_SPD_INVAL    = 9;
  localparam int          A_LAT_TMO      = 10;
  localparam int          A_LAT_CSUM     = 11;
  localparam int          A_LAT_INVAL    = 12;

  // checksum state of the per-source sentence parser
  typedef enum logic [1:0] {CK_IDLE, CK_BODY, CK_HI, CK_LO} nia_ck_state_t;
endpackage

//--- shared/nia_src_if.sv
// interface: per-source sentence results from checker to monitor
`timescale 1ns/100ps
interface nia_src_if;
  logic done;      // one-cycle pulse: a complete sentence ended
  logic csum_bad;  // with done: computed checksum differs
  logic invalid;   // with done: sender flagged data invalid
  modport chk (output done, output csum_bad, output invalid);
  modport mon (input done, input csum_bad, input invalid);
endinterface

//--- hw/nia_sentence_chk.sv
// module: checksum check of one serial sentence stream
`timescale 1ns/100ps
module nia_sentence_chk (
  input  wire logic       clk,        // 10 MHz clock
  input  wire logic       rst_n,      // synchronous reset, active low
  input  wire logic       byte_vld,   // one-cycle strobe for rx_byte
  input  wire logic [7:0] rx_byte,    // received character
  input  wire logic       invalid_in, // sender's data-invalid status for this sentence
  nia_src_if.chk          res         // sentence result
);
  nia_pkg::nia_ck_state_t st_reg;
  nia_pkg::nia_ck_state_t st_next;
  logic [7:0]             xor_reg;
  logic [7:0]             xor_next;
  logic [3:0]             hi_reg;
  logic                   inv_reg;
  logic                   done_reg;
  logic                   bad_reg;
  logic                   inv_out_reg;

  // ascii hex digit to nibble; non-hex reads as 0 and then mismatches
  function automatic logic [3:0] hexval(input logic [7:0] c);
    logic [3:0] v;
    v = 4'h0;
    if (c >= 8'h30 && c <= 8'h39)
      v = c[3:0];
    else if (c >= 8'h41 && c <= 8'h46)
      v = c[3:0] + 4'h9;
    return v;
  endfunction

  wire is_start = byte_vld && (rx_byte == 8'h24 || rx_byte == 8'h21); // '$' or '!'
  wire is_star  = byte_vld && rx_byte == 8'h2a;                       // '*'
  wire [7:0] rx_sum = {hi_reg, hexval(rx_byte)};

  // xor over the body between start and '*', as the sender computes it
  always_comb
  begin
    st_next  = st_reg;
    xor_next = xor_reg;
    if (is_start)
    begin
      st_next  = nia_pkg::CK_BODY;
      xor_next = 8'h00;
    end
    else if (byte_vld)
    begin
      case (st_reg)
        nia_pkg::CK_BODY: if (is_star) st_next = nia_pkg::CK_HI;
                          else xor_next = xor_reg ^ rx_byte;
        nia_pkg::CK_HI:   st_next = nia_pkg::CK_LO;
        nia_pkg::CK_LO:   st_next = nia_pkg::CK_IDLE;
        default:          st_next = nia_pkg::CK_IDLE;
      endcase
    end
  end

  // result pulse on the second checksum digit
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg      <= nia_pkg::CK_IDLE;
      xor_reg     <= 8'h00;
      hi_reg      <= 4'h0;
      inv_reg     <= 1'b0;
      done_reg    <= 1'b0;
      bad_reg     <= 1'b0;
      inv_out_reg <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      xor_reg  <= xor_next;
      done_reg <= byte_vld && !is_start && st_reg == nia_pkg::CK_LO;
      if (byte_vld && st_reg == nia_pkg::CK_HI)
        hi_reg <= hexval(rx_byte);
      if (is_start)
        inv_reg <= 1'b0;
      else if (invalid_in)
        inv_reg <= 1'b1;
      if (byte_vld && !is_start && st_reg == nia_pkg::CK_LO)
      begin
        bad_reg     <= rx_sum != xor_reg;
        inv_out_reg <= inv_reg || invalid_in;
      end
    end
  end

  assign res.done     = done_reg;
  assign res.csum_bad = bad_reg;
  assign res.invalid  = inv_out_reg;
endmodule

//--- hw/nia_monitor.sv
// module: alarm monitor for heading, turn rate, speed and latitude inputs
`timescale 1ns/100ps
module nia_monitor #(
  parameter longint SILENCE_CYCLES = nia_pkg::SILENCE_CYCLES  // silence limit in clocks
) (
  input  wire logic       clk,           // 10 MHz clock
  input  wire logic       rst_n,         // synchronous reset, active low
  input  wire logic [3:0] byte_vld,      // per-source character strobe
  input  wire logic [7:0] rx_byte_hdg,   // heading character
  input  wire logic [7:0] rx_byte_trn,   // turn_rate_input character
  input  wire logic [7:0] rx_byte_spd,   // speed character
  input  wire logic [7:0] rx_byte_lat,   // latitude character
  input  wire logic [3:0] invalid_flag,  // per-source data-invalid status from parser
  input  wire logic       hdg_overrun,   // heading receiver overrun pulse
  input  wire logic       hdg_framing,   // heading receiver framing pulse
  input  wire logic       hdg_parity,    // heading receiver parity pulse
  input  wire logic       auto_spd_corr, // automatic speed error correction selected
  output logic [12:0]     alarm_vec,     // active alarms, one bit per code
  output logic            alarm_any,     // any alarm active
  output logic [9:0]      alarm_code     // lowest active code, 0 when none
);
  localparam logic [nia_pkg::TMR_W-1:0] TMR_MAX =
    nia_pkg::TMR_W'(SILENCE_CYCLES);

  logic [nia_pkg::NUM_ALM-1:0]  alm_reg;
  logic [nia_pkg::NUM_ALM-1:0]  alm_next;
  logic                         any_reg;
  logic [9:0]                   code_reg;
  logic [9:0]                   code_next;
  logic                         proto_reg;
  logic [nia_pkg::NUM_SRC-1:0]  tmo;
  logic [nia_pkg::NUM_SRC-1:0]  done;
  logic [nia_pkg::NUM_SRC-1:0]  bad;
  logic [nia_pkg::NUM_SRC-1:0]  inv;
  logic [7:0]                   bytes [nia_pkg::NUM_SRC];

  assign bytes[nia_pkg::SRC_HEADING]   = rx_byte_hdg;
  assign bytes[nia_pkg::SRC_TURN_RATE] = rx_byte_trn;
  assign bytes[nia_pkg::SRC_SPEED]     = rx_byte_spd;
  assign bytes[nia_pkg::SRC_LATITUDE]  = rx_byte_lat;

  // one checker and one silence timer per source
  genvar g;
  generate
    for (g = 0; g < nia_pkg::NUM_SRC; g++)
    begin : gen_src
      nia_src_if                   sif ();
      logic [nia_pkg::TMR_W-1:0]   tmr_reg;

      nia_sentence_chk u_chk (
        .clk        (clk),
        .rst_n      (rst_n),
        .byte_vld   (byte_vld[g]),
        .rx_byte    (bytes[g]),
        .invalid_in (invalid_flag[g]),
        .res        (sif.chk)
      );

      assign done[g] = sif.done;
      assign bad[g]  = sif.csum_bad;
      assign inv[g]  = sif.invalid;
      // timer saturates; alarm once count reaches the limit
      assign tmo[g]  = tmr_reg == TMR_MAX;

      // restart on each complete sentence
      always_ff @(posedge clk)
      begin
        if (!rst_n || done[g])
          tmr_reg <= '0;
        else if (!tmo[g])
          tmr_reg <= tmr_reg + 1'b1;
      end
    end
  endgenerate

  // receiver faults latch until the next sentence proves the line good
  wire proto_evt = hdg_overrun || hdg_framing || hdg_parity;
  wire gate_sp   = auto_spd_corr; // speed and latitude alarms only under auto correction

  // alarm levels; checksum and invalid stand until the next sentence result
  always_comb
  begin
    alm_next = alm_reg;
    alm_next[nia_pkg::A_HDG_TMO]   = tmo[nia_pkg::SRC_HEADING];
    alm_next[nia_pkg::A_HDG_PROTO] = proto_evt || proto_reg;
    alm_next[nia_pkg::A_TRN_TMO]   = tmo[nia_pkg::SRC_TURN_RATE];
    alm_next[nia_pkg::A_SPD_TMO]   = gate_sp && tmo[nia_pkg::SRC_SPEED];
    alm_next[nia_pkg::A_LAT_TMO]   = gate_sp && tmo[nia_pkg::SRC_LATITUDE];
    if (done[nia_pkg::SRC_HEADING])
    begin
      alm_next[nia_pkg::A_HDG_CSUM]  = bad[nia_pkg::SRC_HEADING];
      alm_next[nia_pkg::A_HDG_INVAL] = inv[nia_pkg::SRC_HEADING];
    end
    if (done[nia_pkg::SRC_TURN_RATE])
    begin
      alm_next[nia_pkg::A_TRN_CSUM]  = bad[nia_pkg::SRC_TURN_RATE];
      alm_next[nia_pkg::A_TRN_INVAL] = inv[nia_pkg::SRC_TURN_RATE];
    end
    if (done[nia_pkg::SRC_SPEED])
    begin
      alm_next[nia_pkg::A_SPD_CSUM]  = bad[nia_pkg::SRC_SPEED];
      alm_next[nia_pkg::A_SPD_INVAL] = inv[nia_pkg::SRC_SPEED];
    end
    if (done[nia_pkg::SRC_LATITUDE])
    begin
      alm_next[nia_pkg::A_LAT_CSUM]  = bad[nia_pkg::SRC_LATITUDE];
      alm_next[nia_pkg::A_LAT_INVAL] = inv[nia_pkg::SRC_LATITUDE];
    end
    if (!gate_sp)
    begin
      // suppression also drops held speed and latitude alarms
      alm_next[nia_pkg::A_SPD_CSUM]  = 1'b0;
      alm_next[nia_pkg::A_SPD_INVAL] = 1'b0;
      alm_next[nia_pkg::A_LAT_CSUM]  = 1'b0;
      alm_next[nia_pkg::A_LAT_INVAL] = 1'b0;
    end
  end

  // lowest active code wins, so the heading group shows first
  always_comb
  begin
    code_next = nia_pkg::CODE_NONE;
    if (alm_next[nia_pkg::A_HDG_TMO])        code_next = nia_pkg::CODE_HDG_TMO;
    else if (alm_next[nia_pkg::A_HDG_PROTO]) code_next = nia_pkg::CODE_HDG_PROTO;
    else if (alm_next[nia_pkg::A_HDG_CSUM])  code_next = nia_pkg::CODE_HDG_CSUM;
    else if (alm_next[nia_pkg::A_HDG_INVAL]) code_next = nia_pkg::CODE_HDG_INVAL;
    else if (alm_next[nia_pkg::A_TRN_TMO])   code_next = nia_pkg::CODE_TRN_TMO;
    else if (alm_next[nia_pkg::A_TRN_CSUM])  code_next = nia_pkg::CODE_TRN_CSUM;
    else if (alm_next[nia_pkg::A_TRN_INVAL]) code_next = nia_pkg::CODE_TRN_INVAL;
    else if (alm_next[nia_pkg::A_SPD_TMO])   code_next = nia_pkg::CODE_SPD_TMO;
    else if (alm_next[nia_pkg::A_SPD_CSUM])  code_next = nia_pkg::CODE_SPD_CSUM;
    else if (alm_next[nia_pkg::A_SPD_INVAL]) code_next = nia_pkg::CODE_SPD_INVAL;
    else if (alm_next[nia_pkg::A_LAT_TMO])   code_next = nia_pkg::CODE_LAT_TMO;
    else if (alm_next[nia_pkg::A_LAT_CSUM])  code_next = nia_pkg::CODE_LAT_CSUM;
    else if (alm_next[nia_pkg::A_LAT_INVAL]) code_next = nia_pkg::CODE_LAT_INVAL;
  end

  // fault event wins over the clearing sentence in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      proto_reg <= 1'b0;
      alm_reg   <= '0;
      any_reg   <= 1'b0;
      code_reg  <= nia_pkg::CODE_NONE;
    end
    else
    begin
      proto_reg <= proto_evt || (proto_reg && !done[nia_pkg::SRC_HEADING]);
      alm_reg   <= alm_next;
      any_reg   <= |alm_next;
      code_reg  <= code_next;
    end
  end

  assign alarm_vec  = alm_reg;
  assign alarm_any  = any_reg;
  assign alarm_code = code_reg;
endmodule

//--- tb/nia_nav_model.sv
// partner model: navigation instruments sending checksummed sentences
`timescale 1ns/100ps
module nia_nav_model (
  input  wire logic       clk,   // bench clock
  output logic      [3:0] vld,   // per-source character strobe
  output logic      [7:0] chr,   // character bus shared by all sources
  output logic      [3:0] inval  // per-source data-invalid status
);
  initial
  begin
    vld = 4'h0;
    chr = 8'h00;
    inval = 4'h0;
  end

  // upper-case hex digit, the only form the receiver accepts
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction

  // one sentence: start, one body char, star, two digits; bad spoils the sum
  task automatic send(input int s, input logic [7:0] body, input logic bad, input logic inv);
    logic [7:0] seq [5];
    logic [7:0] ck;
    ck = body ^ {7'h00, bad};
    seq = '{8'h24, body, 8'h2a, hexc(ck[7:4]), hexc(ck[3:0])};
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      #10;
      vld[s] = 1'b1;
      chr = seq[i];
      inval[s] = inv;
    end
    @(posedge clk);
    #10;
    vld = 4'h0;
    inval = 4'h0;
    chr = ~chr; // released bus must not keep the last char
  endtask
endmodule

//--- tb/nia_monitor_props.sv
// checker: port-level properties of the alarm monitor
`timescale 1ns/100ps
module nia_monitor_props #(
  parameter longint SILENCE_CYCLES = 64'd50  // silence limit in clocks
) (
  input wire logic        clk,           // clock
  input wire logic        rst_n,         // synchronous reset, active low
  input wire logic [3:0]  byte_vld,      // character strobes
  input wire logic [7:0]  rx_byte_hdg,   // heading character
  input wire logic [7:0]  rx_byte_trn,   // turn rate character
  input wire logic [7:0]  rx_byte_spd,   // speed character
  input wire logic [7:0]  rx_byte_lat,   // latitude character
  input wire logic [3:0]  invalid_flag,  // invalid status
  input wire logic        hdg_overrun,   // overrun pulse
  input wire logic        hdg_framing,   // framing pulse
  input wire logic        hdg_parity,    // parity pulse
  input wire logic        auto_spd_corr, // speed correction on
  input wire logic [12:0] alarm_vec,     // active alarms
  input wire logic        alarm_any,     // any alarm
  input wire logic [9:0]  alarm_code     // lowest code
);
  logic [31:0] quiet [2];  // cycles since last heading / turn rate char

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a char restarts the gap count, so it runs at most one clock ahead of the design's timer
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (!rst_n || byte_vld[i]) quiet[i] <= 32'h0;
      else if (quiet[i] != 32'hffff_ffff) quiet[i] <= quiet[i] + 32'h1;
    end
  end

  any_or_a: assert property (alarm_any == (|alarm_vec)) else $error("any flag wrong");
  code_none_a: assert property (alarm_vec == 13'h0 |-> alarm_code == 10'h000)
    else $error("code not zero");
  code_low_a: assert property (alarm_vec[0] |-> alarm_code == 10'd90)
    else $error("code not lowest");
  proto_set_a: assert property ((hdg_overrun || hdg_framing || hdg_parity) |=> alarm_vec[1])
    else $error("protocol alarm missing");
  spd_gate_a: assert property (!auto_spd_corr [*2] |-> alarm_vec[12:7] == 6'h00)
    else $error("speed alarm not gated");
  hdg_early_a: assert property ($rose(alarm_vec[0]) |-> quiet[0] >= SILENCE_CYCLES)
    else $error("heading timeout early");
  trn_late_a: assert property (quiet[1] >= SILENCE_CYCLES + 4 |-> alarm_vec[4])
    else $error("turn rate timeout late");
  csum_hold_a: assert property ($changed(alarm_vec[2]) |-> $past(byte_vld[0], 3))
    else $error("checksum alarm moved alone");
  inval_hold_a: assert property ($changed(alarm_vec[6]) |-> $past(byte_vld[1], 3))
    else $error("invalid alarm moved alone");
endmodule

//--- tb/tb_top.sv
// testbench: self-checking run of the navigation input alarm monitor
`timescale 1ns/100ps
module tb_top;
  localparam longint SIL = 64'd200;  // short silence limit keeps the run brief
  localparam int     CODES [13] = '{90, 91, 92, 93, 94, 96, 97, 100, 102, 103, 110, 112, 113};
  logic        clk;         // bench clock
  logic        rst_n;       // reset, active low
  logic [3:0]  vld;         // strobes from model
  logic [7:0]  chr;         // chars from model
  logic [3:0]  inval;       // invalid status from model
  logic [2:0]  flt;         // overrun, framing, parity
  logic        auto;        // speed correction select
  logic [12:0] alarm_vec;   // alarms seen
  logic        alarm_any;   // any alarm seen
  logic [9:0]  alarm_code;  // code seen
  int          num_errors;  // mismatches
  int          checks;      // comparisons
  int          cyc;         // watchdog count

  nia_nav_model m (.clk(clk), .vld(vld), .chr(chr), .inval(inval));
  nia_monitor #(.SILENCE_CYCLES(SIL)) dut (.clk(clk), .rst_n(rst_n), .byte_vld(vld),
    .rx_byte_hdg(chr), .rx_byte_trn(chr), .rx_byte_spd(chr), .rx_byte_lat(chr),
    .invalid_flag(inval), .hdg_overrun(flt[0]), .hdg_framing(flt[1]), .hdg_parity(flt[2]),
    .auto_spd_corr(auto), .alarm_vec(alarm_vec), .alarm_any(alarm_any),
    .alarm_code(alarm_code));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // lowest active code, worked out from the expected vector
  function automatic logic [9:0] low_code(input logic [12:0] v);
    for (int b = 0; b < 13; b++)
      if (v[b]) return 10'(CODES[b]);
    return 10'h000;
  endfunction

  function automatic logic [7:0] letter();
    return 8'h41 + 8'($urandom % 26);
  endfunction

  task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic expect_vec(input logic [12:0] e);
    check("alarm_vec", alarm_vec, e);
    check("alarm_code", {3'h0, alarm_code}, {3'h0, low_code(e)});
    check("alarm_any", {12'h0, alarm_any}, {12'h0, |e});
  endtask

  task automatic done_test(input string n);
    $display("test %s done, errors so far %0d", n, num_errors);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under this many cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    flt = 3'h0;
    auto = 1'b1;
    num_errors = 0;
    checks = 0;
    void'($urandom(32'h4ac5));
    tick(2);
    rst_n = 1'b1;
    expect_vec(13'h0000);
    for (int s = 0; s < 4; s++) m.send(s, letter(), 1'b0, 1'b0);
    // results land 2 clocks after the last digit, timeout and fault clears 3
    tick(3);
    expect_vec(13'h0000);
    done_test("fresh");
    for (int s = 0; s < 4; s++)
    begin
      m.send(s, letter(), 1'b1, 1'b0);
      tick(3);
      expect_vec(13'h1 << (2 + 3 * s));
      m.send(s, letter(), 1'b0, 1'b1);
      tick(3);
      expect_vec(13'h1 << (3 + 3 * s));
      m.send(s, letter(), 1'b0, 1'b0);
      tick(3);
      expect_vec(13'h0000);
    end
    done_test("sentence");
    for (int f = 0; f < 3; f++)
    begin
      flt = 3'h1 << f;
      tick(1);
      flt = 3'h0;
      tick(1);
      expect_vec(13'h0002);
      m.send(0, letter(), 1'b0, 1'b0);
      tick(3);
      expect_vec(13'h0000);
    end
    done_test("protocol");
    tick(int'(SIL) + 10);
    expect_vec(13'h0491);
    auto = 1'b0;
    tick(2);
    expect_vec(13'h0011);
    m.send(2, letter(), 1'b1, 1'b0);
    tick(3);
    expect_vec(13'h0011);
    m.send(0, letter(), 1'b0, 1'b0);
    tick(3);
    expect_vec(13'h0010);
    auto = 1'b1;
    tick(2);
    expect_vec(13'h0410);
    done_test("timeout");
    wrap_up();
  end
endmodule

bind nia_monitor nia_monitor_props #(.SILENCE_CYCLES(SILENCE_CYCLES)) u_props (.clk(clk),
  .rst_n(rst_n), .byte_vld(byte_vld), .rx_byte_hdg(rx_byte_hdg), .rx_byte_trn(rx_byte_trn),
  .rx_byte_spd(rx_byte_spd), .rx_byte_lat(rx_byte_lat), .invalid_flag(invalid_flag),
  .hdg_overrun(hdg_overrun), .hdg_framing(hdg_framing), .hdg_parity(hdg_parity),
  .auto_spd_corr(auto_spd_corr), .alarm_vec(alarm_vec), .alarm_any(alarm_any),
  .alarm_code(alarm_code));
